// ===== spcff_top.sv
// Purpose: Setpoint source selection, conditioning and feed-forward torque terms.
// Assumes: Analog inputs arrive from outside the clock domain; encoder count and ramp
//    commands come from logic on clk_i.
// Notes: Registers reached over classic Wishbone, one aligned word per register index.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`include "spcff_defs.svh"

module spcff_top
   import spcff_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [15:0] analog_input_one_i,
   input wire logic [15:0] analog_input_two_i,
   input wire logic [15:0] analog_input_three_i,
   input wire logic [15:0] analog_input_four_i,
   input wire logic [31:0] encoder_count_i,
   input wire logic [15:0] ramp_speed_cmd_i,
   input wire logic [15:0] ramp_accel_cmd_i,
   input wire logic [31:0] pid_correction_i,
   output logic [31:0] applied_setpoint_o,
   output logic [31:0] feedforward_torque_o,
   output logic [31:0] regulator_output_o,
   output logic pid_gains_zero_o
);

   spcff_cond_cfg_t cond_cfg;
   spcff_gain_cfg_t gain_cfg;
   logic [31:0] setpoint_delta;
   logic [31:0] host_setpoint_value;
   logic [15:0] setpoint_source_select;

   logic [`SPC_IDX_W-1:0] reg_idx;
   logic bus_req;
   logic bus_wr;
   logic [31:0] read_word;

   logic [15:0] ain_sync1 [4];
   logic [15:0] ain_sync2 [4];
   logic [15:0] ain_sync3 [4];
   logic [15:0] ain_value [4];
   logic [15:0] ain_raw [4];

   logic signed [31:0] raw_setpoint;
   logic signed [48:0] scaled_setpoint;
   logic signed [48:0] biased_setpoint;
   logic signed [31:0] clamped_setpoint;
   logic signed [31:0] held_setpoint;
   logic signed [47:0] smooth_acc;
   logic signed [31:0] applied_setpoint;

   logic signed [48:0] next_scaled;
   logic signed [48:0] next_biased;
   logic signed [31:0] next_clamped;
   logic signed [32:0] held_diff;
   logic [32:0] held_mag;
   logic signed [48:0] smooth_step;
   logic [3:0] smooth_shift;
   logic signed [32:0] ff_sum;
   logic signed [32:0] reg_sum;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic [31:0] saturate33(input logic signed [32:0] v);
      if (v[32] != v[31]) begin
         return v[32] ? `SPC_SAT_NEG : `SPC_SAT_POS;
      end
      return v[31:0];
   endfunction

   assign reg_idx = wb_adr_i[`SPC_IDX_W+1:2];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i;

   // Bus answer: one wait state, ack for one cycle, unmapped indices read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `SPC_RST_ZERO32;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= read_word;
         end
      end
   end

   always_comb begin
      read_word = `SPC_RST_ZERO32;
      case (reg_idx)
         `SPC_IDX_KP: read_word = {16'h0000, gain_cfg.proportional_gain};
         `SPC_IDX_KI: read_word = {16'h0000, gain_cfg.integral_gain};
         `SPC_IDX_KD: read_word = {16'h0000, gain_cfg.derivative_gain};
         `SPC_IDX_FRICTION: read_word = {16'h0000, gain_cfg.speed_feedforward_gain};
         `SPC_IDX_INERTIA: read_word = {16'h0000, gain_cfg.accel_feedforward_gain};
         `SPC_IDX_DELTA: read_word = setpoint_delta;
         `SPC_IDX_HOST: read_word = host_setpoint_value;
         `SPC_IDX_SELECT: read_word = {16'h0000, setpoint_source_select};
         `SPC_IDX_MUL: read_word = {16'h0000, cond_cfg.multiplier};
         `SPC_IDX_DIV: read_word = {16'h0000, cond_cfg.divisor};
         `SPC_IDX_BIAS: read_word = {16'h0000, cond_cfg.bias};
         `SPC_IDX_LOWER: read_word = cond_cfg.lower_bound;
         `SPC_IDX_UPPER: read_word = cond_cfg.upper_bound;
         `SPC_IDX_DEADZONE: read_word = {16'h0000, cond_cfg.deadzone};
         `SPC_IDX_SMOOTH: read_word = {16'h0000, cond_cfg.smoothing};
         `SPC_IDX_APPLIED: read_word = applied_setpoint;
         default: read_word = `SPC_RST_ZERO32;
      endcase
   end

   // Host setpoint and relative adjust share one process so a delta write updates it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setpoint_delta <= `SPC_RST_ZERO32;
         host_setpoint_value <= `SPC_RST_ZERO32;
      end else if (bus_wr) begin
         if (reg_idx == `SPC_IDX_DELTA) begin
            setpoint_delta <= merge_bytes(setpoint_delta, wb_dat_i, wb_sel_i);
            host_setpoint_value <= host_setpoint_value
               + merge_bytes(setpoint_delta, wb_dat_i, wb_sel_i);
         end else if (reg_idx == `SPC_IDX_HOST) begin
            host_setpoint_value <= merge_bytes(host_setpoint_value, wb_dat_i,
                                               wb_sel_i);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         setpoint_source_select <= `SPC_SRC_HOST;
         cond_cfg.multiplier <= `SPC_RST_MUL;
         cond_cfg.divisor <= `SPC_RST_DIV;
         cond_cfg.bias <= `SPC_RST_ZERO16;
         cond_cfg.lower_bound <= `SPC_RST_LOWER;
         cond_cfg.upper_bound <= `SPC_RST_UPPER;
         cond_cfg.deadzone <= `SPC_RST_ZERO16;
         cond_cfg.smoothing <= `SPC_RST_ZERO16;
      end else if (bus_wr) begin
         case (reg_idx)
            `SPC_IDX_SELECT: setpoint_source_select <= 16'(merge_bytes(
               {16'h0000, setpoint_source_select}, wb_dat_i, wb_sel_i));
            `SPC_IDX_MUL: cond_cfg.multiplier <= 16'(merge_bytes(
               {16'h0000, cond_cfg.multiplier}, wb_dat_i, wb_sel_i));
            `SPC_IDX_DIV: cond_cfg.divisor <= 16'(merge_bytes(
               {16'h0000, cond_cfg.divisor}, wb_dat_i, wb_sel_i));
            `SPC_IDX_BIAS: cond_cfg.bias <= 16'(merge_bytes(
               {16'h0000, cond_cfg.bias}, wb_dat_i, wb_sel_i));
            `SPC_IDX_LOWER: cond_cfg.lower_bound <= merge_bytes(
               cond_cfg.lower_bound, wb_dat_i, wb_sel_i);
            `SPC_IDX_UPPER: cond_cfg.upper_bound <= merge_bytes(
               cond_cfg.upper_bound, wb_dat_i, wb_sel_i);
            `SPC_IDX_DEADZONE: cond_cfg.deadzone <= 16'(merge_bytes(
               {16'h0000, cond_cfg.deadzone}, wb_dat_i, wb_sel_i));
            `SPC_IDX_SMOOTH: cond_cfg.smoothing <= 16'(merge_bytes(
               {16'h0000, cond_cfg.smoothing}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_cfg <= '0;
      end else if (bus_wr) begin
         case (reg_idx)
            `SPC_IDX_KP: gain_cfg.proportional_gain <= 16'(merge_bytes(
               {16'h0000, gain_cfg.proportional_gain}, wb_dat_i, wb_sel_i));
            `SPC_IDX_KI: gain_cfg.integral_gain <= 16'(merge_bytes(
               {16'h0000, gain_cfg.integral_gain}, wb_dat_i, wb_sel_i));
            `SPC_IDX_KD: gain_cfg.derivative_gain <= 16'(merge_bytes(
               {16'h0000, gain_cfg.derivative_gain}, wb_dat_i, wb_sel_i));
            `SPC_IDX_FRICTION: gain_cfg.speed_feedforward_gain <= 16'(merge_bytes(
               {16'h0000, gain_cfg.speed_feedforward_gain}, wb_dat_i, wb_sel_i));
            `SPC_IDX_INERTIA: gain_cfg.accel_feedforward_gain <= 16'(merge_bytes(
               {16'h0000, gain_cfg.accel_feedforward_gain}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   assign ain_raw[0] = analog_input_one_i;
   assign ain_raw[1] = analog_input_two_i;
   assign ain_raw[2] = analog_input_three_i;
   assign ain_raw[3] = analog_input_four_i;

   // A new converter word is taken only once two late stages agree, so a word
   // caught mid-change is never used
   for (genvar g = 0; g < 4; g++) begin : g_ain
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ain_sync1[g] <= `SPC_RST_ZERO16;
            ain_sync2[g] <= `SPC_RST_ZERO16;
            ain_sync3[g] <= `SPC_RST_ZERO16;
            ain_value[g] <= `SPC_RST_ZERO16;
         end else begin
            ain_sync1[g] <= ain_raw[g];
            ain_sync2[g] <= ain_sync1[g];
            ain_sync3[g] <= ain_sync2[g];
            if (ain_sync2[g] == ain_sync3[g]) begin
               ain_value[g] <= ain_sync3[g];
            end
         end
      end
   end

   // Stage 1: source selection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         raw_setpoint <= `SPC_RST_ZERO32;
      end else begin
         case (setpoint_source_select)
            `SPC_SRC_ANALOG_INPUT_ONE: raw_setpoint <= {16'h0000, ain_value[0]};
            `SPC_SRC_ANALOG_INPUT_TWO: raw_setpoint <= {16'h0000, ain_value[1]};
            `SPC_SRC_ANALOG_INPUT_THREE: raw_setpoint <= {16'h0000, ain_value[2]};
            `SPC_SRC_ANALOG_INPUT_FOUR: raw_setpoint <= {16'h0000, ain_value[3]};
            `SPC_SRC_ENC: raw_setpoint <= encoder_count_i;
            default: raw_setpoint <= host_setpoint_value;
         endcase
      end
   end

   // Stage 2 and 3: scale, then bias; a zero divisor acts as one to avoid a fault
   always_comb begin
      next_scaled = raw_setpoint * $signed({1'b0, cond_cfg.multiplier});
      if (cond_cfg.divisor != `SPC_RST_ZERO16) begin
         next_scaled = next_scaled / $signed({1'b0, cond_cfg.divisor});
      end
      next_biased = scaled_setpoint + $signed({1'b0, cond_cfg.bias});
      next_clamped = biased_setpoint[31:0];
      if (biased_setpoint < $signed(cond_cfg.lower_bound)) begin
         next_clamped = cond_cfg.lower_bound;
      end else if (biased_setpoint > $signed(cond_cfg.upper_bound)) begin
         next_clamped = cond_cfg.upper_bound;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scaled_setpoint <= '0;
         biased_setpoint <= '0;
         clamped_setpoint <= `SPC_RST_ZERO32;
      end else begin
         scaled_setpoint <= next_scaled;
         biased_setpoint <= next_biased;
         clamped_setpoint <= next_clamped;
      end
   end

   // Deadzone sits after bias and clamp; a zero or negative setting passes through
   always_comb begin
      held_diff = clamped_setpoint - held_setpoint;
      held_mag = held_diff[32] ? 33'(-held_diff) : held_diff;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         held_setpoint <= `SPC_RST_ZERO32;
      end else if ($signed(cond_cfg.deadzone) <= 16'sh0000) begin
         held_setpoint <= clamped_setpoint;
      end else if (held_mag >= 33'(cond_cfg.deadzone)) begin
         held_setpoint <= clamped_setpoint;
      end
   end

   // Filter keeps fraction bits so small steps still creep to the target
   always_comb begin
      smooth_shift = (cond_cfg.smoothing > `SPC_SMOOTH_MAX) ? 4'hf : cond_cfg.smoothing[3:0];
      smooth_step = ($signed({held_setpoint, 16'h0000}) - smooth_acc) >>> smooth_shift;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         smooth_acc <= '0;
      end else if (cond_cfg.smoothing == `SPC_RST_ZERO16) begin
         smooth_acc <= {held_setpoint, 16'h0000};
      end else begin
         smooth_acc <= 48'(smooth_acc + smooth_step);
      end
   end

   assign applied_setpoint = smooth_acc[47:`SPC_FRAC_BITS];

   // Feed-forward from ramp commands; raw product, scaling sits in the gain units
   always_comb begin
      ff_sum = 33'($signed(ramp_speed_cmd_i) * $signed(gain_cfg.speed_feedforward_gain))
         + 33'($signed(ramp_accel_cmd_i) * $signed(gain_cfg.accel_feedforward_gain));
      reg_sum = $signed(saturate33(ff_sum)) + $signed(pid_correction_i);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         applied_setpoint_o <= `SPC_RST_ZERO32;
         feedforward_torque_o <= `SPC_RST_ZERO32;
         regulator_output_o <= `SPC_RST_ZERO32;
         pid_gains_zero_o <= 1'b1;
      end else begin
         applied_setpoint_o <= applied_setpoint;
         feedforward_torque_o <= saturate33(ff_sum);
         pid_gains_zero_o <= (gain_cfg.proportional_gain == `SPC_RST_ZERO16)
            && (gain_cfg.integral_gain == `SPC_RST_ZERO16)
            && (gain_cfg.derivative_gain == `SPC_RST_ZERO16);
         if ((gain_cfg.proportional_gain | gain_cfg.integral_gain
              | gain_cfg.derivative_gain) == `SPC_RST_ZERO16) begin
            regulator_output_o <= saturate33(ff_sum);
         end else begin
            regulator_output_o <= saturate33(reg_sum);
         end
      end
   end

endmodule

// ===== spcff_defs.svh
// Purpose: Constants for the setpoint conditioning and feed-forward block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Included by bare name; definitions only.
`ifndef SPCFF_DEFS_SVH
`define SPCFF_DEFS_SVH

`define SPC_IDX_W 10
`define SPC_IDX_KP 10'h12c
`define SPC_IDX_KI 10'h12d
`define SPC_IDX_KD 10'h12e
`define SPC_IDX_FRICTION 10'h131
`define SPC_IDX_INERTIA 10'h132
`define SPC_IDX_DELTA 10'h1c0
`define SPC_IDX_HOST 10'h1c2
`define SPC_IDX_SELECT 10'h1c4
`define SPC_IDX_MUL 10'h1c5
`define SPC_IDX_DIV 10'h1c6
`define SPC_IDX_BIAS 10'h1c7
`define SPC_IDX_LOWER 10'h1c8
`define SPC_IDX_UPPER 10'h1ca
`define SPC_IDX_DEADZONE 10'h1cc
`define SPC_IDX_SMOOTH 10'h1cd
`define SPC_IDX_APPLIED 10'h1ce

`define SPC_RST_ZERO32 32'h0000_0000
`define SPC_RST_ZERO16 16'h0000
`define SPC_RST_MUL 16'h0001
`define SPC_RST_DIV 16'h0001
`define SPC_RST_LOWER 32'h8000_0000
`define SPC_RST_UPPER 32'h7fff_ffff

`define SPC_SRC_HOST 16'h0000
`define SPC_SRC_ANALOG_INPUT_ONE 16'h0001
`define SPC_SRC_ANALOG_INPUT_TWO 16'h0002
`define SPC_SRC_ANALOG_INPUT_THREE 16'h0003
`define SPC_SRC_ANALOG_INPUT_FOUR 16'h0004
`define SPC_SRC_ENC 16'h0005

`define SPC_FRAC_BITS 16
`define SPC_SMOOTH_MAX 16'h000f
`define SPC_SAT_POS 32'h7fff_ffff
`define SPC_SAT_NEG 32'h8000_0000

`endif

// ===== spcff_pkg.sv
// Purpose: Types shared by the setpoint conditioning block.
// Assumes: Constants live in spcff_defs.svh.
// Notes: Configuration travels as two packed structs, one for conditioning and one for gains.
package spcff_pkg;

   typedef struct packed {
      logic [15:0] multiplier;
      logic [15:0] divisor;
      logic [15:0] bias;
      logic [31:0] lower_bound;
      logic [31:0] upper_bound;
      logic [15:0] deadzone;
      logic [15:0] smoothing;
   } spcff_cond_cfg_t;

   typedef struct packed {
      logic [15:0] proportional_gain;
      logic [15:0] integral_gain;
      logic [15:0] derivative_gain;
      logic [15:0] speed_feedforward_gain;
      logic [15:0] accel_feedforward_gain;
   } spcff_gain_cfg_t;

endpackage

// ===== spcff_far_model.sv
// Purpose: Far-side sources: converters, encoder, ramp generator and PID core.
// Assumes: Values change only just after rising clock edges.
// Notes: Bench loads next values by task; nothing moves between loads.
`timescale 1ns/1ps
module spcff_far_model (
   input wire logic clk_i,
   output logic [15:0] ain_o [4],
   output logic [31:0] enc_o,
   output logic [15:0] spd_o,
   output logic [15:0] acc_o,
   output logic [31:0] pid_o
);
   logic [15:0] next_ain [4] = '{default: 16'h0};
   logic [31:0] next_enc = 32'h0;
   logic [31:0] next_pid = 32'h0;
   logic [15:0] next_spd = 16'h0;
   logic [15:0] next_acc = 16'h0;
   task automatic load(input logic [15:0] a [4], input logic [31:0] e);
      next_ain = a;
      next_enc = e;
   endtask
   task automatic ramp(input logic [15:0] s, input logic [15:0] c, input logic [31:0] p);
      next_spd = s;
      next_acc = c;
      next_pid = p;
   endtask
   initial begin
      ain_o = '{default: 16'h0};
      enc_o = 32'h0;
      spd_o = 16'h0;
      acc_o = 16'h0;
      pid_o = 32'h0;
   end
   always @(posedge clk_i) begin
      ain_o <= next_ain;
      enc_o <= next_enc;
      spd_o <= next_spd;
      acc_o <= next_acc;
      pid_o <= next_pid;
   end
endmodule

// ===== spcff_top_props.sv
// Purpose: Port-level properties of spcff_top.
// Assumes: One clock domain; only top ports are visible.
// Notes: Gains are internal, so products are judged by the bench.
`timescale 1ns/1ps
`include "spcff_defs.svh"
module spcff_top_props
   import spcff_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [15:0] ramp_speed_cmd_i,
   input wire logic [15:0] ramp_accel_cmd_i,
   input wire logic [31:0] applied_setpoint_o,
   input wire logic [31:0] feedforward_torque_o,
   input wire logic [31:0] regulator_output_o,
   input wire logic pid_gains_zero_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic take;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   property p_ack_next;
      take |=> wb_ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("no ack one cycle after request");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_ack_cause;
      wb_ack_o |-> $past(take);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   property p_dat_hold;
      !$past(take && !wb_we_i) |-> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold)
      else $error("read data moved without a read");
   property p_applied_rd;
      wb_ack_o && $past(!wb_we_i && wb_adr_i[11:2] == `SPC_IDX_APPLIED)
         |-> wb_dat_o == applied_setpoint_o;
   endproperty
   a_applied_rd: assert property (p_applied_rd)
      else $error("applied readback differs from output");
   property p_unmapped;
      wb_ack_o && $past(!wb_we_i && wb_adr_i[11:2] == 10'h1c1) |-> wb_dat_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_sel_res;
      wb_ack_o && $past(!wb_we_i && wb_adr_i[11:2] == `SPC_IDX_SELECT)
         |-> wb_dat_o[31:16] == 16'h0;
   endproperty
   a_sel_res: assert property (p_sel_res)
      else $error("selector upper bits not zero");
   property p_ff_zero;
      $past(ramp_speed_cmd_i == 16'h0 && ramp_accel_cmd_i == 16'h0)
         |-> feedforward_torque_o == 32'h0;
   endproperty
   a_ff_zero: assert property (p_ff_zero)
      else $error("feed-forward nonzero with idle ramp");
   property p_ff_only;
      pid_gains_zero_o && $past(pid_gains_zero_o) && $past(pid_gains_zero_o, 2)
         && $stable(feedforward_torque_o) |-> regulator_output_o == feedforward_torque_o;
   endproperty
   a_ff_only: assert property (p_ff_only)
      else $error("regulator not feed-forward only");
   property p_reset;
      disable iff (1'b0) rst_i |=> applied_setpoint_o == 32'h0 && pid_gains_zero_o
         && !wb_ack_o && regulator_output_o == 32'h0;
   endproperty
   a_reset: assert property (p_reset)
      else $error("outputs not cleared by reset");
   c_applied_rd: cover property (take && !wb_we_i && wb_adr_i[11:2] == `SPC_IDX_APPLIED);
   c_pid_on: cover property ($fell(pid_gains_zero_o));
   c_ff_live: cover property (pid_gains_zero_o && feedforward_torque_o != 32'h0);
endmodule
bind spcff_top spcff_top_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .ramp_speed_cmd_i(ramp_speed_cmd_i),
   .ramp_accel_cmd_i(ramp_accel_cmd_i), .applied_setpoint_o(applied_setpoint_o),
   .feedforward_torque_o(feedforward_torque_o), .regulator_output_o(regulator_output_o),
   .pid_gains_zero_o(pid_gains_zero_o));

// ===== spcff_top_bench.sv
// Purpose: Self-checking bench for spcff_top.
// Assumes: Byte address is four times the register index.
// Notes: Expected values come from an integer model of the pipeline.
`timescale 1ns/1ps
`include "spcff_defs.svh"
module spcff_top_bench;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, gz;
   logic [31:0] adr = 32'h0, dat = 32'h0, rdata, dat_o, sp_o, ff_o, reg_o, enc, pid, r32;
   logic [3:0] sel = 4'hf;
   logic [15:0] ain [4], ain_v [4], spd, acc;
   int bad_count = 0, num_checks = 0, m_sel = 0, m_mul = 1, m_div = 1, m_bias = 0;
   int m_host = 0, m_lo = 32'h8000_0000, m_hi = 32'h7fff_ffff, enc_v = 0;
   int m_in, m_sp, m_ac, m_pid, ffx;
   logic [31:0] rs = 32'h271c;
   logic [9:0] ri [6] = '{`SPC_IDX_SELECT, `SPC_IDX_HOST, `SPC_IDX_MUL, `SPC_IDX_DIV,
      `SPC_IDX_LOWER, `SPC_IDX_UPPER};
   logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h1, 32'h1, `SPC_RST_LOWER, `SPC_RST_UPPER};
   logic [9:0] gi [3] = '{`SPC_IDX_KP, `SPC_IDX_KI, `SPC_IDX_KD};
   always #5 clk_i = ~clk_i;
   spcff_far_model far (.clk_i(clk_i), .ain_o(ain), .enc_o(enc), .spd_o(spd), .acc_o(acc),
      .pid_o(pid));
   spcff_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .analog_input_one_i(ain[0]), .analog_input_two_i(ain[1]), .analog_input_three_i(ain[2]),
      .analog_input_four_i(ain[3]), .encoder_count_i(enc), .ramp_speed_cmd_i(spd),
      .ramp_accel_cmd_i(acc), .pid_correction_i(pid), .applied_setpoint_o(sp_o),
      .feedforward_torque_o(ff_o), .regulator_output_o(reg_o), .pid_gains_zero_o(gz));
   function automatic logic [31:0] nxt();
      rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
      return rs;
   endfunction
   function automatic int sat(longint v);
      if (v > longint'(32'sh7fff_ffff)) return 32'sh7fff_ffff;
      if (v < longint'(32'sh8000_0000)) return 32'sh8000_0000;
      return int'(v);
   endfunction
   function automatic logic [31:0] model_sp();
      longint r;
      r = (m_sel >= 1 && m_sel <= 4) ? int'(ain_v[m_sel-1]) : (m_sel == 5 ? enc_v : m_host);
      r = r * m_mul / (m_div == 0 ? 1 : m_div) + m_bias;
      if (r < m_lo) r = m_lo;
      if (r > m_hi) r = m_hi;
      return r[31:0];
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Holds the request until ack is sampled; read data is taken at that edge
   task automatic bus(input int w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= (w != 0);
      adr <= {20'h0, idx, 2'b00};
      dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rdata = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // Twenty cycles covers the seven-stage path plus the analog synchroniser
   task automatic settle(input string nm);
      repeat (20) @(posedge clk_i);
      chk(nm, model_sp(), sp_o);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk_i);
      bad_count++;
      close_out();
   end
   initial begin
      ain_v = '{default: 16'h0};
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ri[i]) begin
         bus(0, ri[i], 0);
         chk("reset value", rv[i], rdata);
      end
      bus(1, 10'h1c1, 32'hffff_ffff);
      bus(0, 10'h1c1, 0);
      chk("unmapped", 32'h0, rdata);
      m_host = 100;
      bus(1, `SPC_IDX_HOST, m_host);
      settle("host source");
      bus(1, `SPC_IDX_DELTA, 32'hffff_ffff);
      m_host = m_host - 1;
      bus(0, `SPC_IDX_DELTA, 0);
      chk("delta readback", 32'hffff_ffff, rdata);
      bus(0, `SPC_IDX_HOST, 0);
      chk("host after delta", m_host, rdata);
      settle("delta applied");
      m_host = -99;
      bus(1, `SPC_IDX_HOST, m_host);
      for (int i = 0; i < 2; i++) begin
         m_mul = i ? 1 : 3;
         m_div = i ? 0 : 2;
         m_bias = i ? 0 : 16'hfff0;
         bus(1, `SPC_IDX_MUL, m_mul);
         bus(1, `SPC_IDX_DIV, m_div);
         bus(1, `SPC_IDX_BIAS, m_bias);
         settle("scale offset");
      end
      for (int i = 0; i < 3; i++) begin
         m_lo = i != 0 ? 32'h8000_0000 : -10;
         m_hi = i == 1 ? -200 : 32'h7fff_ffff;
         bus(1, `SPC_IDX_LOWER, m_lo);
         bus(1, `SPC_IDX_UPPER, m_hi);
         settle("clamp");
      end
      for (int s = 0; s < 7; s++) begin
         foreach (ain_v[k]) begin
            r32 = nxt();
            ain_v[k] = {1'b1, r32[14:0]};
         end
         enc_v = nxt();
         far.load(ain_v, enc_v);
         m_sel = s;
         bus(1, `SPC_IDX_SELECT, m_sel);
         settle("source select");
      end
      m_sel = 0;
      bus(1, `SPC_IDX_SELECT, m_sel);
      bus(1, `SPC_IDX_DEADZONE, 32'd10);
      bus(1, `SPC_IDX_HOST, -94);
      repeat (20) @(posedge clk_i);
      chk("deadzone hold", -99, sp_o);
      m_host = -89;
      bus(1, `SPC_IDX_HOST, m_host);
      settle("deadzone edge");
      bus(1, `SPC_IDX_DEADZONE, 32'd0);
      bus(1, `SPC_IDX_SMOOTH, 32'd2);
      m_host = 911;
      bus(1, `SPC_IDX_HOST, m_host);
      repeat (10) @(posedge clk_i);
      chk("filter partial", 1, $signed(sp_o) > -89 && $signed(sp_o) < 911);
      repeat (200) @(posedge clk_i);
      chk("filter settled", 1, $signed(sp_o) >= 910 && $signed(sp_o) <= 911);
      bus(1, `SPC_IDX_SMOOTH, 32'd0);
      settle("smoothing off");
      bus(0, `SPC_IDX_APPLIED, 0);
      chk("applied readback", model_sp(), rdata);
      bus(1, `SPC_IDX_FRICTION, 32'd100);
      for (int i = 0; i < 5; i++) begin
         r32 = nxt();
         m_in = $signed(r32[31:16]);
         m_sp = $signed(r32[15:0]);
         r32 = nxt();
         m_ac = $signed(r32[15:0]);
         m_pid = nxt();
         if (i == 4) bus(1, `SPC_IDX_KP, 32'd5);
         bus(1, `SPC_IDX_INERTIA, m_in);
         far.ramp(16'(m_sp), 16'(m_ac), m_pid);
         repeat (5) @(posedge clk_i);
         ffx = sat(longint'(m_sp) * 100 + longint'(m_ac) * m_in);
         chk("feedforward", ffx, ff_o);
         chk("regulator", i == 4 ? sat(longint'(ffx) + m_pid) : ffx, reg_o);
         chk("gains zero", {31'h0, i != 4}, {31'h0, gz});
      end
      // Each of the three gains alone must take the regulator off feed-forward only
      foreach (gi[g]) begin
         bus(1, gi[g], 32'd3);
         bus(0, gi[g], 0);
         chk("gain readback", 32'd3, rdata);
         repeat (3) @(posedge clk_i);
         chk("gains zero", 32'h0, {31'h0, gz});
         chk("regulator", sat(longint'(ffx) + m_pid), reg_o);
         bus(1, gi[g], 0);
      end
      repeat (3) @(posedge clk_i);
      chk("gains zero", 32'h1, {31'h0, gz});
      chk("regulator", ffx, reg_o);
      close_out();
   end
endmodule
